// [rtl/wdt_core.sv]
// Purpose: 8-bit watchdog / interval timer with overflow handling
// Assumes: one core clock, synchronous active-high reset from a pin
// Notes: the internal chip reset spares the watchdog-reset flag
// Functional notes
// - mode 0, enabled: interval interrupt per overflow
// - overflow sets flag plus reset or interrupt
// - watchdog flag set only when mode, enable high
// - watchdog overflow sets flag, asserts chip reset
// - chip reset clears overflow, keeps watchdog flag
// - in mode 0, interval interrupt held while overflow flag reads one
// - counter write beats a coincident increment
// - overflow is wrap from ff to 00
// - internal reset lasts 518 states
// - disabled counter held at zero
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
module wdt_core
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // events
  output logic interval_overflow_interrupt_o,
  output logic chip_reset_o,
  output logic irq_o
);
  localparam int PRESCALE_BITS_W = wdt_pkg::PRESCALE_BITS;

  typedef struct packed {
    logic [7:0] count;
    logic overflow_flag;
    logic watchdog_or_interval_select;
    logic counter_enable_bit;
    logic [2:0] clock_select_bits;
    logic watchdog_reset_flag;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [PRESCALE_BITS_W-1:0] prescale;
    logic [9:0] reset_count;
    logic chip_reset;
    logic [7:0] rdata;
  } wdt_state_t;

  wdt_state_t st_reg;
  wdt_state_t st_next;
  logic tick;
  logic ovf_event;
  logic count_wr;
  logic int_rst;

  // tick select: one pulse per period of the chosen prescaled clock
  function automatic logic tick_sel(input logic [2:0] cks,
                                    input logic [PRESCALE_BITS_W-1:0] p);
    logic [PRESCALE_BITS_W-1:0] m;
    m = '0;
    case (cks)
      3'h0: m = 12'h001;
      3'h1: m = 12'h01f;
      3'h2: m = 12'h03f;
      3'h3: m = 12'h07f;
      3'h4: m = 12'h0ff;
      3'h5: m = 12'h1ff;
      3'h6: m = 12'h7ff;
      default: m = 12'hfff;
    endcase
    return (p & m) == m;
  endfunction

  assign int_rst = st_reg.chip_reset;
  // key in the upper byte guards against stray writes from a runaway program
  assign count_wr = reg_wr_i && reg_addr_i == wdt_pkg::TIMER_COUNTER_VALUE_OFS
                    && reg_wdata_i[15:8] == 8'h5a;
  assign tick = st_reg.counter_enable_bit && tick_sel(st_reg.clock_select_bits, st_reg.prescale);
  assign ovf_event = tick && !count_wr && st_reg.count == wdt_pkg::COUNT_MAX;

  always_comb
  begin
    st_next = st_reg;
    st_next.prescale = st_reg.prescale + 12'h001;
    st_next.rdata = 8'h00;
    // counter
    if (!st_reg.counter_enable_bit)
    begin
      st_next.count = wdt_pkg::COUNT_RESET;
      st_next.prescale = '0;
    end
    else if (count_wr)
    begin
      st_next.count = reg_wdata_i[7:0];
    end
    else if (tick)
    begin
      st_next.count = st_reg.count + 8'h01;
    end
    // control writes
    if (reg_wr_i && reg_addr_i == wdt_pkg::TIMER_CONTROL_STATUS_OFS && reg_wdata_i[15:8] == 8'ha5)
    begin
      // changing clock select while running is the user's hazard
      st_next.watchdog_or_interval_select = reg_wdata_i[wdt_pkg::MODE_POS];
      st_next.counter_enable_bit = reg_wdata_i[wdt_pkg::ENABLE_POS];
      st_next.clock_select_bits = reg_wdata_i[wdt_pkg::CKS_LSB +: 3];
      if (!reg_wdata_i[wdt_pkg::OVF_POS])
        st_next.overflow_flag = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == wdt_pkg::RESET_CONTROL_STATUS_OFS
        && reg_wdata_i[15:8] == 8'ha5 && !reg_wdata_i[wdt_pkg::WATCHDOG_RESET_FLAG_POS])
      st_next.watchdog_reset_flag = 1'b0;
    if (reg_wr_i && reg_addr_i == wdt_pkg::IRQ_STATUS_OFS)
      st_next.irq_status = st_reg.irq_status & ~reg_wdata_i[1:0];
    if (reg_wr_i && reg_addr_i == wdt_pkg::IRQ_MASK_OFS)
      st_next.irq_mask = reg_wdata_i[1:0];
    // overflow: set wins over any clear in the same cycle
    if (ovf_event)
    begin
      st_next.overflow_flag = 1'b1;
      st_next.irq_status[wdt_pkg::IRQ_OVF_POS] = 1'b1;
      if (st_reg.watchdog_or_interval_select && st_reg.counter_enable_bit)
      begin
        st_next.watchdog_reset_flag = 1'b1;
        st_next.irq_status[wdt_pkg::IRQ_WATCHDOG_RESET_FLAG_POS] = 1'b1;
        st_next.chip_reset = 1'b1;
        st_next.reset_count = wdt_pkg::WDT_RESET_CYCLES - 10'd1;
      end
    end
    // internal reset countdown
    if (st_reg.chip_reset)
    begin
      if (st_reg.reset_count == 10'd0)
        st_next.chip_reset = 1'b0;
      else
        st_next.reset_count = st_reg.reset_count - 10'd1;
    end
    // reads
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        wdt_pkg::TIMER_CONTROL_STATUS_OFS:
          st_next.rdata = {st_reg.overflow_flag, st_reg.watchdog_or_interval_select,
                           st_reg.counter_enable_bit, 2'b00, st_reg.clock_select_bits}
                          | wdt_pkg::CTRL_RESERVED_ONES;
        wdt_pkg::TIMER_COUNTER_VALUE_OFS: st_next.rdata = st_reg.count;
        wdt_pkg::RESET_CONTROL_STATUS_OFS:
          st_next.rdata = {st_reg.watchdog_reset_flag, 7'h00} | wdt_pkg::RSTC_RESERVED_ONES;
        wdt_pkg::IRQ_STATUS_OFS: st_next.rdata = {6'h00, st_reg.irq_status};
        wdt_pkg::IRQ_MASK_OFS: st_next.rdata = {6'h00, st_reg.irq_mask};
        default: st_next.rdata = 8'h00;
      endcase
    end
    // internal reset clears count, overflow flag, mode, enable, clock select and prescaler
    if (int_rst)
    begin
      st_next.count = wdt_pkg::COUNT_RESET;
      st_next.overflow_flag = 1'b0;
      st_next.watchdog_or_interval_select = 1'b0;
      st_next.counter_enable_bit = 1'b0;
      st_next.clock_select_bits = wdt_pkg::CKS_RESET;
      st_next.prescale = '0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  // interval request follows the overflow flag in interval mode
  assign interval_overflow_interrupt_o = st_reg.overflow_flag && !st_reg.watchdog_or_interval_select;
  assign chip_reset_o = st_reg.chip_reset;
  assign irq_o = |(st_reg.irq_status & st_reg.irq_mask);
endmodule

// [rtl/wdt_pkg.sv]
// Purpose: constants for the watchdog / interval timer block
// Assumes: 20 MHz core clock, plain register port
// Notes: register offsets are word indices on the plain port
package wdt_pkg;
  // register offsets
  localparam logic [3:0] TIMER_CONTROL_STATUS_OFS = 4'h0;
  localparam logic [3:0] TIMER_COUNTER_VALUE_OFS = 4'h1;
  localparam logic [3:0] RESET_CONTROL_STATUS_OFS = 4'h2;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h3;
  localparam logic [3:0] IRQ_MASK_OFS = 4'h4;
  // timer_control_status fields
  localparam int OVF_POS = 7;
  localparam int MODE_POS = 6;
  localparam int ENABLE_POS = 5;
  localparam int CKS_LSB = 0;
  localparam logic [7:0] CTRL_RESERVED_ONES = 8'h18;
  // reset_control_status fields
  localparam int WATCHDOG_RESET_FLAG_POS = 7;
  localparam logic [7:0] RSTC_RESERVED_ONES = 8'h3f;
  // interrupt status bits
  localparam int IRQ_OVF_POS = 0;
  localparam int IRQ_WATCHDOG_RESET_FLAG_POS = 1;
  // reset values and count maximum
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [2:0] CKS_RESET = 3'h0;
  // internal reset length, in states (core clock cycles)
  localparam int WDT_RESET_STATES = 518;
  localparam logic [9:0] WDT_RESET_CYCLES = 10'(WDT_RESET_STATES);
  // prescaler
  localparam int PRESCALE_BITS = 12;
endpackage

// [testbench/wdt_chk.sv]
// Purpose: port checks for wdt_core
// Assumes: one clock, sync reset
// Notes: bound to the top module
`timescale 1ns/10ps
module wdt_chk
(
  // watched ports
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic interval_overflow_interrupt_o,
  input wire logic chip_reset_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [9:0] cnt_reg;
  always_ff @(posedge core_clk_i)
    cnt_reg <= (rst_i || !chip_reset_o) ? 10'h000 : cnt_reg + 10'h001;
  sequence s_go;
    $rose(chip_reset_o);
  endsequence
  a_rst_len: assert property ($fell(chip_reset_o) |-> cnt_reg == 10'h206)
    else $error("chip reset length wrong");
  a_rst_max: assert property (cnt_reg <= 10'h206)
    else $error("chip reset too long");
  a_rst_hold: assert property (s_go |=> chip_reset_o [*8])
    else $error("chip reset dropped early");
  a_rst_no_ivl: assert property (chip_reset_o |-> !interval_overflow_interrupt_o)
    else $error("interval irq during chip reset");
  a_ivl_hold: assert property (interval_overflow_interrupt_o && !reg_wr_i |=>
    interval_overflow_interrupt_o) else $error("interval irq lost");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(reg_wr_i))
    else $error("irq fell without write");
  a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside slot");
  a_rel_quiet: assert property ($fell(rst_i) |-> !chip_reset_o && !irq_o)
    else $error("outputs busy after reset");
endmodule
bind wdt_core wdt_chk wdt_chk_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .interval_overflow_interrupt_o(interval_overflow_interrupt_o),
  .chip_reset_o(chip_reset_o), .irq_o(irq_o));

// [testbench/wdt_core_tb.sv]
// Purpose: self-checking bench for wdt_core
// Assumes: 50 ns clock, sync reset
// Notes: counts are short enough to run full length
`timescale 1ns/10ps
module wdt_core_tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] a = 4'h0;
  logic [15:0] d = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] q;
  logic ivl, crst, irq;
  logic [9:0] len;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #25 core_clk_i = ~core_clk_i;
  wdt_core wdt_core_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(a),
    .reg_wdata_i(d), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(q),
    .interval_overflow_interrupt_o(ivl), .chip_reset_o(crst), .irq_o(irq));
  wdt_rst_sink wdt_rst_sink_inst (.core_clk_i(core_clk_i), .chip_reset_i(crst), .len_o(len));
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr_t(logic [3:0] ad, logic [15:0] dt);
    @(posedge core_clk_i);
    a <= ad;
    d <= dt;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_t(logic [3:0] ad, logic [9:0] e, string n);
    @(posedge core_clk_i);
    a <= ad;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    chk(n, e, 10'(q));
  endtask
  task automatic t_ivl();
    wr_t(4'h4, 16'h0001);
    wr_t(4'h0, 16'ha520);
    wr_t(4'h1, 16'h5a80);
    rd_t(4'h1, 10'h080, "load");
    wr_t(4'h0, 16'ha500);
    rd_t(4'h1, 10'h000, "held");
    wr_t(4'h0, 16'ha520);
    for (int i = 0; i < 600 && ivl !== 1'b1; i++) @(posedge core_clk_i) #1;
    chk("ivl", 10'h001, 10'(ivl));
    chk("crst", 10'h000, 10'(crst));
    rd_t(4'h0, 10'h0b8, "ovf");
    rd_t(4'h2, 10'h03f, "rstc");
    wr_t(4'h4, 16'h0000);
    chk("mask", 10'h000, 10'(irq));
    wr_t(4'h4, 16'h0001);
    chk("irq", 10'h001, 10'(irq));
    wr_t(4'h0, 16'ha520);
    chk("ivlclr", 10'h000, 10'(ivl));
    wr_t(4'h3, 16'h0001);
    chk("irqclr", 10'h000, 10'(irq));
    $display("test interval done");
  endtask
  task automatic t_wd();
    wr_t(4'h4, 16'h0002);
    wr_t(4'h0, 16'ha560);
    wr_t(4'h1, 16'h5afe);
    for (int i = 0; i < 20 && crst !== 1'b1; i++) @(posedge core_clk_i) #1;
    for (int i = 0; i < 600 && crst !== 1'b0; i++) @(posedge core_clk_i) #1;
    @(posedge core_clk_i) #1;
    chk("len", 10'h206, len);
    rd_t(4'h0, 10'h018, "ctrl");
    rd_t(4'h2, 10'h0bf, "watchdog_reset_flag");
    chk("irq", 10'h001, 10'(irq));
    wr_t(4'h2, 16'ha500);
    rd_t(4'h2, 10'h03f, "wclr");
    wr_t(4'h3, 16'h0002);
    chk("irqclr", 10'h000, 10'(irq));
    $display("test watchdog done");
  endtask
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_t(4'h0, 10'h018, "ctrl0");
    rd_t(4'h5, 10'h000, "unmapped");
    t_ivl();
    t_wd();
    tally_and_finish();
  end
endmodule

// [testbench/wdt_rst_sink.sv]
// Purpose: chip reset logic stand-in
// Assumes: level reset request
// Notes: keeps the length of the last pulse
`timescale 1ns/10ps
module wdt_rst_sink
(
  // inputs
  input wire logic core_clk_i,
  input wire logic chip_reset_i,
  // measured pulse
  output logic [9:0] len_o
);
  logic [9:0] run_reg = 10'h000;
  always @(posedge core_clk_i)
  begin
    run_reg <= chip_reset_i ? run_reg + 10'h001 : 10'h000;
    if (!chip_reset_i && run_reg != 10'h000) len_o <= run_reg;
  end
endmodule
